// *** core/hpcs_pkg.sv ***
// Constants for the hot-plug power-on reset and control-select block.
// Assumes a single 100 MHz clock and inputs already synchronous to it.
package hpcs_pkg;
  localparam int unsigned CLK_FREQ_HZ   = 100_000_000;
  localparam int unsigned POR_QUAL_US   = 250;
  // The clock is a whole number of megahertz, so the qualification count is exact.
  localparam int unsigned POR_QUAL_CYC  = POR_QUAL_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int unsigned NUM_SLOTS     = 2;
  localparam int unsigned GPI_COUNT     = 2;
  localparam int unsigned STAT_W        = 8;

  typedef enum logic [1:0] {
    HPCS_OFF,
    HPCS_QUAL,
    HPCS_RUN
  } hpcs_state_type;
endpackage : hpcs_pkg

// *** core/hpcs_core.sv ***
// Power-on reset sequencer and power-control source selector for two slots.
// Assumes the standby-valid comparator and all pins are synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module hpcs_core
  import hpcs_pkg::*;
#(
  parameter int unsigned POR_CYCLES = POR_QUAL_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 standby_supply_ok,
  input  wire logic                 mgmt_pins_strapped_off,
  input  wire logic                 mgmt_control_sel,
  input  wire logic [NUM_SLOTS-1:0] main_enable,
  input  wire logic [NUM_SLOTS-1:0] slot_aux_enable,
  input  wire logic [NUM_SLOTS-1:0] mgmt_main_bit,
  input  wire logic [NUM_SLOTS-1:0] mgmt_aux_bit,
  input  wire logic [NUM_SLOTS-1:0] slot_fault_event,
  input  wire logic [GPI_COUNT-1:0] general_input_pins,
  input  wire logic [STAT_W-1:0]    supply_status,
  output logic                      por_active,
  output logic                      management_interface_ready,
  output logic                      mgmt_power_write_allowed,
  output logic                      regs_clear,
  output logic [NUM_SLOTS-1:0]      gate_drive_3v_source_on,
  output logic [NUM_SLOTS-1:0]      gate_drive_12v_sink_on,
  output logic [NUM_SLOTS-1:0]      gate_drive_12v_pullup_on,
  output logic [NUM_SLOTS-1:0]      gate_drive_3v_pulldown_on,
  output logic [NUM_SLOTS-1:0]      aux_output_on,
  output logic [NUM_SLOTS-1:0]      slot_fault_n,
  output logic [GPI_COUNT-1:0]      report_gpi,
  output logic [STAT_W-1:0]         report_status
);

  hpcs_state_type state_r;
  hpcs_state_type state_nxt;
  logic [31:0]    cnt_r;
  logic [31:0]    cnt_nxt;
  logic           done_r;
  logic           done_nxt;

  // Sequencer: any standby dropout returns to OFF, so the full qualification reruns.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    done_nxt  = 1'b0;
    unique case (state_r)
      HPCS_OFF: begin
        cnt_nxt = 32'h0000_0000;
        if (standby_supply_ok) begin
          state_nxt = HPCS_QUAL;
        end
      end
      HPCS_QUAL: begin
        if (!standby_supply_ok) begin
          state_nxt = HPCS_OFF;
        end else if (cnt_r == POR_CYCLES - 1) begin
          state_nxt = HPCS_RUN;
          done_nxt  = 1'b1;
        end else begin
          cnt_nxt = cnt_r + 32'h0000_0001;
        end
      end
      HPCS_RUN: begin
        if (!standby_supply_ok) begin
          state_nxt = HPCS_OFF;
        end
      end
      default: begin
        state_nxt = HPCS_OFF;
      end
    endcase
  end

  // Registers only; reset constants.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= HPCS_OFF;
      cnt_r   <= 32'h0000_0000;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      done_r  <= done_nxt;
    end
  end

  logic                 run;
  logic [NUM_SLOTS-1:0] main_req;
  logic [NUM_SLOTS-1:0] aux_req;
  logic [NUM_SLOTS-1:0] main_on_r;
  logic [NUM_SLOTS-1:0] main_on_nxt;
  logic [NUM_SLOTS-1:0] aux_on_r;
  logic [NUM_SLOTS-1:0] aux_on_nxt;
  logic [NUM_SLOTS-1:0] fault_n_r;
  logic [NUM_SLOTS-1:0] fault_n_nxt;
  logic [GPI_COUNT-1:0] gpi_r;
  logic [GPI_COUNT-1:0] gpi_nxt;
  logic [STAT_W-1:0]    stat_r;
  logic [STAT_W-1:0]    stat_nxt;

  assign run = (state_r == HPCS_RUN);
  // Management bus is dead while strapped off or before reset completes.
  assign management_interface_ready = run && !mgmt_pins_strapped_off;
  // Power-control writes are blocked in hardwired mode; other accesses still go through.
  assign mgmt_power_write_allowed   = management_interface_ready && mgmt_control_sel;
  assign por_active                 = !run;
  assign regs_clear                 = done_r;

  // Select the power-control source; the other source is ignored, so nothing relies on
  // the controller not driving both.
  always_comb begin
    main_req = mgmt_control_sel ? mgmt_main_bit : main_enable;
    aux_req  = mgmt_control_sel ? mgmt_aux_bit : slot_aux_enable;
    if (!mgmt_control_sel || mgmt_pins_strapped_off) begin
      main_req = main_enable;
      aux_req  = slot_aux_enable;
    end
  end

  // Output state: levels followed every cycle so drive drops with the enable.
  always_comb begin
    main_on_nxt = run ? main_req : '0;
    aux_on_nxt  = run ? aux_req : '0;
    fault_n_nxt = ~(slot_fault_event & main_req & {NUM_SLOTS{run && !mgmt_control_sel}});
    gpi_nxt     = run ? general_input_pins : '0;
    stat_nxt    = run ? supply_status : '0;
  end

  // Output registers; reset leaves every slot off and the fault pins released.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      main_on_r <= '0;
      aux_on_r  <= '0;
      fault_n_r <= '1;
      gpi_r     <= '0;
      stat_r    <= '0;
    end else begin
      main_on_r <= main_on_nxt;
      aux_on_r  <= aux_on_nxt;
      fault_n_r <= fault_n_nxt;
      gpi_r     <= gpi_nxt;
      stat_r    <= stat_nxt;
    end
  end

  // Off slot: 12 V gate held high, 3.3 V gate held low; on slot: constant currents.
  assign gate_drive_3v_source_on   = main_on_r;
  assign gate_drive_12v_sink_on    = main_on_r;
  assign gate_drive_12v_pullup_on  = ~main_on_r;
  assign gate_drive_3v_pulldown_on = ~main_on_r;
  assign aux_output_on             = aux_on_r;
  assign slot_fault_n              = fault_n_r;
  assign report_gpi                = gpi_r;
  assign report_status             = stat_r;

  // Checker-only count of consecutive standby-good samples. It saturates, so a very
  // long good spell cannot wrap round and make a short qualification pass unseen.
  logic [31:0] ok_cnt_r;
  logic [31:0] ok_cnt_nxt;

  // Next standby-good count; any dropout starts it again from zero.
  always_comb begin
    ok_cnt_nxt = ok_cnt_r;
    if (!standby_supply_ok) begin
      ok_cnt_nxt = 32'h0000_0000;
    end else if (ok_cnt_r != 32'hffff_ffff) begin
      ok_cnt_nxt = ok_cnt_r + 32'h0000_0001;
    end
  end

  // Register of the standby-good count, cleared with the rest of the block.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ok_cnt_r <= 32'h0000_0000;
    end else begin
      ok_cnt_r <= ok_cnt_nxt;
    end
  end

  // Assertions.
  // Eight good standby samples in a row: far too short to finish qualification.
  sequence s_qual_run;
    standby_supply_ok [*8];
  endsequence

  // One clear pulse at the end of reset, gone again a cycle later.
  sequence s_clear_then_quiet;
    regs_clear ##1 !regs_clear;
  endsequence

  // After a dropout the sequencer stays out of RUN for at least two samples.
  sequence s_held_out;
    !run ##1 !run;
  endsequence

  // Slot outputs and reports stay cleared while reset is still running.
  a_outputs_off_por: assert property (@(posedge clk) disable iff (!reset_n)
    !run |=> (main_on_r == '0) && (aux_on_r == '0))
    else $error("slot output on during reset");

  a_gate_off_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !run |=> (gate_drive_12v_pullup_on == '1) && (gate_drive_3v_pulldown_on == '1))
    else $error("gate not held when off");

  a_report_cleared: assert property (@(posedge clk) disable iff (!reset_n)
    !run |=> (report_status == '0) && (report_gpi == '0) && (slot_fault_n == '1))
    else $error("report not cleared during reset");

  // Gate drive follows the main request one cycle later and drops with it.
  a_gate_on_drive: assert property (@(posedge clk) disable iff (!reset_n)
    run && $stable(run) && main_req[0] |=> gate_drive_3v_source_on[0] && gate_drive_12v_sink_on[0])
    else $error("gate not driven on enable");

  a_enable_drop: assert property (@(posedge clk) disable iff (!reset_n)
    !main_req[1] |=> !gate_drive_3v_source_on[1])
    else $error("drive not withdrawn");

  // Power-on reset sequencing. The qualification is checked against the helper
  // count above, so a sequencer that counted short would be caught.
  a_dropout_restart: assert property (@(posedge clk) disable iff (!reset_n)
    !standby_supply_ok |=> s_held_out)
    else $error("no restart after dropout");

  a_qual_start: assert property (@(posedge clk) disable iff (!reset_n)
    (state_r == HPCS_OFF) && standby_supply_ok ##1 s_qual_run |-> !run)
    else $error("qualification too short");

  a_qual_length: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(run) |-> ok_cnt_r > POR_CYCLES)
    else $error("run reached before full qualification");

  a_clear_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    regs_clear |-> run && $past(state_r) == HPCS_QUAL ##1 !regs_clear)
    else $error("clear pulse wrong");

  a_clear_on_run: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(run) |-> s_clear_then_quiet)
    else $error("no clear pulse at end of reset");

  // Management bus gating. Ready may only follow a completed qualification, whose
  // final count the sequencer keeps for as long as it stays in RUN.
  a_bus_ready_gate: assert property (@(posedge clk) disable iff (!reset_n)
    management_interface_ready |-> run && (cnt_r == POR_CYCLES - 1) && !mgmt_pins_strapped_off)
    else $error("bus ready too early");

  a_bus_ready_open: assert property (@(posedge clk) disable iff (!reset_n)
    regs_clear && !mgmt_pins_strapped_off |-> management_interface_ready)
    else $error("bus not ready at end of reset");

  // Power-control source. A strapped-off bus falls back to the hardwired enables,
  // so a slot never waits on control bits that can no longer be written.
  a_main_managed: assert property (@(posedge clk) disable iff (!reset_n)
    run && mgmt_control_sel && !mgmt_pins_strapped_off |=> gate_drive_3v_source_on == $past(mgmt_main_bit))
    else $error("main not following control bits");

  a_main_hardwired: assert property (@(posedge clk) disable iff (!reset_n)
    run && (!mgmt_control_sel || mgmt_pins_strapped_off) |=> gate_drive_3v_source_on == $past(main_enable))
    else $error("main not following enable pins");

  a_aux_select: assert property (@(posedge clk) disable iff (!reset_n)
    run && $stable(run) && !mgmt_control_sel |=> aux_output_on == $past(slot_aux_enable))
    else $error("aux not following pins");

  a_aux_managed: assert property (@(posedge clk) disable iff (!reset_n)
    run && mgmt_control_sel && !mgmt_pins_strapped_off |=> aux_output_on == $past(mgmt_aux_bit))
    else $error("aux not following control bits");

  // Fault pin and reported values.
  a_fault_path: assert property (@(posedge clk) disable iff (!reset_n)
    mgmt_control_sel |=> slot_fault_n == '1)
    else $error("fault pin in managed mode");

  a_fault_report: assert property (@(posedge clk) disable iff (!reset_n)
    run && !mgmt_control_sel |=> slot_fault_n == ~$past(slot_fault_event & main_enable))
    else $error("fault pin not reporting");

  a_gpi_report: assert property (@(posedge clk) disable iff (!reset_n)
    run |=> report_gpi == $past(general_input_pins))
    else $error("gpi report stale");

  a_status_report: assert property (@(posedge clk) disable iff (!reset_n)
    run |=> report_status == $past(supply_status))
    else $error("status report stale");

  // Per-slot gate pairs: both currents switch together, and both holds return
  // together, so a slot never has its source and its pull-down fighting.
  for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot_chk
    a_slot_on_drive: assert property (@(posedge clk) disable iff (!reset_n)
      run && main_req[g] |=> gate_drive_3v_source_on[g] && gate_drive_12v_sink_on[g])
      else $error("slot gate currents not on");

    a_slot_off_hold: assert property (@(posedge clk) disable iff (!reset_n)
      !run || !main_req[g] |=> gate_drive_12v_pullup_on[g] && gate_drive_3v_pulldown_on[g]
        && !gate_drive_12v_sink_on[g])
      else $error("slot gate not held off");

    a_slot_aux_off: assert property (@(posedge clk) disable iff (!reset_n)
      !run |=> !aux_output_on[g])
      else $error("slot aux on during reset");
  end

endmodule : hpcs_core
`default_nettype wire

// *** testbench/hpcs_host_model.sv ***
// Host side of the slot controls: one power-control source at a time.
// Assumes requests arrive from the bench just after a clock edge.
`timescale 1ns/100ps
`default_nettype none
module hpcs_host_model
  import hpcs_pkg::*;
(
  input  wire logic                 sel,
  input  wire logic [NUM_SLOTS-1:0] req_main,
  input  wire logic [NUM_SLOTS-1:0] req_aux,
  output logic      [NUM_SLOTS-1:0] main_enable,
  output logic      [NUM_SLOTS-1:0] slot_aux_enable,
  output logic      [NUM_SLOTS-1:0] mgmt_main_bit,
  output logic      [NUM_SLOTS-1:0] mgmt_aux_bit
);
  // The unused source is tied off so a lost bus link leaves the slots safe.
  assign main_enable     = sel ? '0 : req_main;
  assign slot_aux_enable = sel ? '0 : req_aux;
  assign mgmt_main_bit   = sel ? req_main : '0;
  assign mgmt_aux_bit    = sel ? req_aux : '0;
endmodule : hpcs_host_model
`default_nettype wire

// *** testbench/test_hotplug_por_and_control_select.sv ***
// Self-checking bench: random slot requests against a cycle model.
// Assumes hpcs_pkg and the host model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_hotplug_por_and_control_select;
  import hpcs_pkg::*;
  localparam int POR = 10;
  logic                 clk, reset_n, sok, strap, sel, pa, rdy, wa, rc, e_rc;
  logic [NUM_SLOTS-1:0] rm, ra, me, ae, mm, ma, fe, src, snk, pu, pd, aux, fn, e_on, e_aux, e_fn;
  logic [GPI_COUNT-1:0] gpi, rgpi, e_g;
  logic [STAT_W-1:0]    st, rst, e_s;
  int                   errors, n_checks, run, cnt, cyc;

  hpcs_host_model u_hpcs_host_model (.sel(sel), .req_main(rm), .req_aux(ra), .main_enable(me),
    .slot_aux_enable(ae), .mgmt_main_bit(mm), .mgmt_aux_bit(ma));
  hpcs_core #(.POR_CYCLES(POR)) u_hpcs_core (.clk(clk), .reset_n(reset_n), .standby_supply_ok(sok),
    .mgmt_pins_strapped_off(strap), .mgmt_control_sel(sel), .main_enable(me), .slot_aux_enable(ae),
    .mgmt_main_bit(mm), .mgmt_aux_bit(ma), .slot_fault_event(fe), .general_input_pins(gpi),
    .supply_status(st), .por_active(pa), .management_interface_ready(rdy), .mgmt_power_write_allowed(wa),
    .regs_clear(rc), .gate_drive_3v_source_on(src), .gate_drive_12v_sink_on(snk),
    .gate_drive_12v_pullup_on(pu), .gate_drive_3v_pulldown_on(pd), .aux_output_on(aux),
    .slot_fault_n(fn), .report_gpi(rgpi), .report_status(rst));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Reference model: outputs follow the state held before each edge.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run = 0; cnt = -1; e_rc = 1'b0; e_on = '0; e_aux = '0; e_fn = '1; e_g = '0; e_s = '0;
    end else begin
      e_on  = run ? ((sel && !strap) ? mm : me) : '0;
      e_aux = run ? ((sel && !strap) ? ma : ae) : '0;
      e_fn  = (run && !sel) ? ~(me & fe) : '1;
      e_g   = run ? gpi : '0;
      e_s   = run ? st : '0;
      e_rc  = 1'b0;
      if (!sok) begin
        run = 0; cnt = -1;
      end else if (cnt < 0) begin
        cnt = 0;
      end else if (run == 0) begin
        cnt++;
        if (cnt == POR) begin
          run = 1; e_rc = 1'b1;
        end
      end
    end
  end

  // Compare mid-cycle, once every registered output has settled.
  always @(negedge clk) begin
    check(32'({pa, rdy, wa, rc}), 32'({run == 0, run != 0 && !strap, run != 0 && sel && !strap, e_rc}));
    check(32'({src, snk, pu, pd}), 32'({e_on, e_on, ~e_on, ~e_on}));
    check(32'({aux, fn}), 32'({e_aux, e_fn}));
    check(32'({rgpi, rst}), 32'({e_g, e_s}));
  end

  // A hang is cut short well past the planned run length.
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      errors++;
      close_out();
    end
  end

  initial begin
    reset_n = 1'b0; sok = 1'b0; strap = 1'b0; sel = 1'b0; rm = '0; ra = '0; fe = '0; gpi = '0; st = '0;
    void'($urandom(32'hdb0233e6));
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (3000) begin
      @(posedge clk);
      #1;
      reset_n = ($urandom % 1000) != 0;
      sok = ($urandom % 150) != 0;
      if ($urandom % 100 == 0) sel = ~sel;
      if ($urandom % 300 == 0) strap = ~strap;
      rm = NUM_SLOTS'($urandom);
      ra = NUM_SLOTS'($urandom);
      fe = NUM_SLOTS'($urandom);
      gpi = GPI_COUNT'($urandom);
      st = STAT_W'($urandom);
    end
    close_out();
  end
endmodule : test_hotplug_por_and_control_select
`default_nettype wire
